// ==== hw/audio_dac_serial_control_decoder.sv ====
// serial control link receiver and register decoder for the audio converter
`include "audio_ctrl_defs.svh"

module audio_dac_serial_control_decoder import audio_ctrl_pkg::*; #(
	parameter logic [5:0] DEVICE_ADDR = 6'h2A // arbitrary value
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic ctrl_data_line,
	input wire logic ctrl_framing_line,
	input wire logic ctrl_clock_line,
	input wire logic control_source_select,
	input wire logic sample_tick,
	output logic link_selected,
	output logic [5:0] left_att_db,
	output logic [5:0] right_att_db,
	output logic left_att_mute,
	output logic right_att_mute,
	output logic [1:0] tone_set,
	output logic [4:0] bass_gain_db,
	output logic [4:0] treble_gain_db,
	output logic deemph_active,
	output logic [1:0] left_source,
	output logic [1:0] right_source,
	output logic [5:0] left_mute_level,
	output logic [5:0] right_mute_level,
	output logic left_headroom_short,
	output logic right_headroom_short
);

	// -------------------------------------------------------------
	// code maps
	// -------------------------------------------------------------
	// bass codes follow a non-binary order; step count in 2 dB units
	function automatic logic [3:0] bass_step(input logic [4:0] code);
		logic [3:0] s;
		s = 4'hC;
		case (code)
			5'h00, 5'h01: s = 4'h0;
			5'h02: s = 4'h1;
			5'h03: s = 4'h2;
			5'h04: s = 4'h3;
			5'h05: s = 4'h4;
			5'h07: s = 4'h5;
			5'h06: s = 4'h6;
			5'h09: s = 4'h7;
			5'h08: s = 4'h8;
			5'h0B: s = 4'h9;
			5'h0A: s = 4'hA;
			5'h0D: s = 4'hB;
			default: s = 4'hC;
		endcase
		return s;
	endfunction

	// treble codes move in pairs; everything past 5 saturates
	function automatic logic [2:0] treble_step(input logic [4:0] code);
		logic [2:0] s;
		s = `TREBLE_MAX_STEPS;
		if (code < 5'h06) begin
			s = code[3:1];
		end
		return s;
	endfunction

	// -------------------------------------------------------------
	// state
	// -------------------------------------------------------------
	ctrl_state_t q;
	ctrl_state_t n;
	logic serial;
	logic rise;
	logic frame_chg;
	logic byte_done;
	logic [7:0] byte_val;
	logic [1:0] ts;
	logic [3:0] bstep;
	logic [5:0] code;
	logic [1:0] route;
	logic mute_req;
	logic [6:0] boost;

	// next state: link decode, register loads, setting decode
	always_comb begin
		n = q;
		ts = TONE_FLAT;
		bstep = 4'h0;
		code = 6'h00;
		route = ROUTE_MUTE;
		mute_req = 1'b0;
		boost = 7'h00;
		// link pins pass two flops; link runs far below core clock
		n.lnk_s1 = {ctrl_clock_line, ctrl_framing_line, ctrl_data_line};
		n.lnk_s2 = q.lnk_s1;
		n.lnk_s3 = q.lnk_s2[2:1];
		n.src_s1 = control_source_select;
		n.src_s2 = q.src_s1;
		serial = q.src_s2;
		rise = q.lnk_s2[2] & ~q.lnk_s3[1];
		frame_chg = q.lnk_s2[1] ^ q.lnk_s3[0];
		byte_done = serial & rise & ~frame_chg & (q.bit_cnt == 3'h7);
		byte_val = {q.shift, q.lnk_s2[0]};

		// bit counter restarts on any mode-line change
		if (frame_chg | ~serial) begin
			n.bit_cnt = 3'h0;
		end else if (rise) begin
			n.bit_cnt = q.bit_cnt + 3'h1;
			n.shift = byte_val[6:0];
		end

		// address phase with mode low; data bytes with mode high
		if (byte_done) begin
			if (!q.lnk_s2[1]) begin
				n.selected = (byte_val[`ADDR_DEV_MSB:`ADDR_DEV_LSB] == DEVICE_ADDR);
				n.group = byte_val[1:0];
			end else if (q.selected) begin
				// unused groups fall through and store nothing
				if (q.group == GRP_LEVEL) begin
					case (byte_val[7:6])
						2'h0: n.att_code[1] = byte_val[5:0];
						2'h1: n.att_code[0] = byte_val[5:0];
						2'h2: n.bass_code = byte_val[4:0];
						2'h3: n.treble_code = byte_val[4:0];
						default: n.att_code = q.att_code;
					endcase
				end else if (q.group == GRP_STATUS && !byte_val[7]) begin
					n.status = byte_val[6:0];
				end
			end
		end

		// tone set: pins force flat
		if (serial) begin
			case (q.status[`ST_TONE_HI:`ST_TONE_LO])
				2'h0: ts = TONE_FLAT;
				2'h1, 2'h2: ts = TONE_MIN;
				2'h3: ts = TONE_MAX;
				default: ts = TONE_FLAT;
			endcase
		end else begin
			ts = TONE_FLAT;
		end
		n.tone_set = ts;
		bstep = bass_step(q.bass_code);
		case (ts)
			TONE_MIN: begin
				n.bass_db = {(bstep > `BASS_MIN_STEPS) ? `BASS_MIN_STEPS : bstep, 1'b0};
				n.treble_db = {1'b0, treble_step(q.treble_code), 1'b0};
			end
			TONE_MAX: begin
				n.bass_db = {bstep, 1'b0};
				n.treble_db = {1'b0, treble_step(q.treble_code), 1'b0};
			end
			default: begin
				n.bass_db = 5'h00;
				n.treble_db = 5'h00;
			end
		endcase

		// de-emphasis moves only between samples
		if (sample_tick) begin
			n.deemph = serial ? q.status[`ST_DEEMPH] : q.lnk_s2[2];
		end

		// per channel: attenuation, routing, soft mute ramp, clip hint
		for (int ch = 0; ch < 2; ch++) begin
			code = serial ? q.att_code[ch] : 6'h00;
			n.att_mute[ch] = (code > `ATT_LAST_CODE);
			n.att_db[ch] = (code < 6'h02) ? 6'h00 : code - 6'h01;
			if (serial) begin
				route = (ch == 0) ? q.status[`ST_LROUTE_HI:`ST_LROUTE_LO]
					: q.status[`ST_RROUTE_HI:`ST_RROUTE_LO];
				mute_req = (route == ROUTE_MUTE);
			end else begin
				route = (ch == 0) ? ROUTE_LEFT : ROUTE_RIGHT;
				mute_req = (ch == 0) ? q.lnk_s2[0] : q.lnk_s2[1];
			end
			// source holds its last audible choice while ramping down
			if (!mute_req) begin
				n.src[ch] = route;
			end
			if (sample_tick) begin
				if (mute_req ? (q.mute_lvl[ch] != 6'h00) : (q.mute_lvl[ch] != `MUTE_COEFS)) begin
					if (q.mute_cnt[ch] == `MUTE_HOLD) begin
						n.mute_cnt[ch] = 5'h00;
						n.mute_lvl[ch] = mute_req ? q.mute_lvl[ch] - 6'h01 : q.mute_lvl[ch] + 6'h01;
					end else begin
						n.mute_cnt[ch] = q.mute_cnt[ch] + 5'h01;
					end
				end else begin
					n.mute_cnt[ch] = 5'h00;
				end
			end
			// no headroom: a boost larger than the attenuation clips
			boost = {2'b00, q.bass_db} + {2'b00, q.treble_db};
			n.clip[ch] = ~q.att_mute[ch] & (boost > {1'b0, q.att_db[ch]});
		end
	end

	// register the whole state; synchronous reset
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			q <= '0;
			q.status <= `STATUS_RST;
			q.src[0] <= ROUTE_LEFT;
			q.src[1] <= ROUTE_RIGHT;
			q.mute_lvl[0] <= `MUTE_COEFS;
			q.mute_lvl[1] <= `MUTE_COEFS;
		end else begin
			q <= n;
		end
	end

	// -------------------------------------------------------------
	// outputs, each straight from the state register
	// -------------------------------------------------------------
	assign link_selected = q.selected;
	assign left_att_db = q.att_db[0];
	assign right_att_db = q.att_db[1];
	assign left_att_mute = q.att_mute[0];
	assign right_att_mute = q.att_mute[1];
	assign tone_set = q.tone_set;
	assign bass_gain_db = q.bass_db;
	assign treble_gain_db = q.treble_db;
	assign deemph_active = q.deemph;
	assign left_source = q.src[0];
	assign right_source = q.src[1];
	assign left_mute_level = q.mute_lvl[0];
	assign right_mute_level = q.mute_lvl[1];
	assign left_headroom_short = q.clip[0];
	assign right_headroom_short = q.clip[1];

	// -------------------------------------------------------------
	// checks
	// -------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	a_static_flat_tone: assert property (!q.src_s2 |=> q.tone_set == TONE_FLAT)
		else $error("tone set not flat in pin mode");
	a_static_zero_att: assert property (!q.src_s2 |=> q.att_db[0] == 6'h00 && !q.att_mute[1])
		else $error("attenuation not zero in pin mode");
	a_att_code_map: assert property (q.src_s2 && q.att_code[0] == 6'h38 |=> q.att_db[0] == 6'h37)
		else $error("attenuation code 56 not 55 dB");
	a_att_full_mute: assert property (q.src_s2 && q.att_code[1] > 6'h38 |=> q.att_mute[1])
		else $error("attenuation above 56 not muted");
	a_commit_on_eighth: assert property ($changed(q.att_code) |-> $past(byte_done))
		else $error("register changed without a full byte");
	// the shift register drops byte bit 7, so compare byte bits 7:2 as they were on the eighth rise
	a_addr_select: assert property (byte_done && !q.lnk_s2[1] |=> q.selected == ($past(byte_val[7:2]) == DEVICE_ADDR))
		else $error("selection does not follow address");
	a_group_held: assert property (byte_done && q.lnk_s2[1] |=> $stable(q.group) && $stable(q.selected))
		else $error("selection changed in data phase");
	a_bit_restart: assert property (frame_chg |=> q.bit_cnt == 3'h0)
		else $error("bit count not restarted on mode change");
	a_deemph_sample: assert property ($changed(q.deemph) |-> $past(sample_tick))
		else $error("de-emphasis changed mid sample");
	a_ramp_sample: assert property ($changed(q.mute_lvl) |-> $past(sample_tick) && $past(q.mute_cnt) != 10'h000)
		else $error("mute level stepped off schedule");
	a_static_route: assert property (!q.src_s2 && !q.lnk_s2[0] |=> q.src[0] == ROUTE_LEFT)
		else $error("left output not left in pin mode");

	c_address_hit: cover property (byte_done && !q.lnk_s2[1] ##1 q.selected);
	c_status_write: cover property (byte_done && q.selected && q.group == GRP_STATUS);
	c_full_mute: cover property (q.mute_lvl[0] == 6'h01 ##[1:1000] q.mute_lvl[0] == 6'h00);
	c_clip_hint: cover property (q.clip[0]);

endmodule

// ==== inc/audio_ctrl_defs.svh ====
// constants for the serial control decoder: fields, reset values, code limits, timing counts
//
// Summary of operation
// - address phase: mode low, eight clocked bits
// - address bits 1:0 choose register group
// - address bits 7:2 compared to own address
// - foreign address deselects; data bytes ignored
// - selection persists until next address phase
// - byte committed only after eighth bit
// - data bits 7:6 select register, 5:0 value
// - level group: right, left, bass, treble
// - status byte: mode, de-emphasis, two routings
// - mode 00 flat, 01/10 min, 11 max
// - de-emphasis bit enables 44.1 kHz filter
// - de-emphasis changes only on sample boundaries
// - routing: mute, right, left, half sum
// - attenuation 1 dB steps, above 56 mutes
// - bass steps 2 dB, saturates 18/24
// - treble pairs step 2 dB, saturate 6
// - static mode forces flat tone, straight routing
// - static mode fixes attenuation at 0 dB
// - volume precedes tone; boost may clip
// - routing mute uses soft ramp
// - source select high serial, low pins
// - 32 coefficients, 32 samples each, reversible
`ifndef AUDIO_CTRL_DEFS_SVH
`define AUDIO_CTRL_DEFS_SVH

// -------------------------------------------------------------
// byte fields
// -------------------------------------------------------------
`define ADDR_DEV_MSB 7
`define ADDR_DEV_LSB 2
`define ST_TONE_HI 6
`define ST_TONE_LO 5
`define ST_DEEMPH 4
`define ST_RROUTE_HI 3
`define ST_RROUTE_LO 2
`define ST_LROUTE_HI 1
`define ST_LROUTE_LO 0

// -------------------------------------------------------------
// reset values, code limits and timing counts
// -------------------------------------------------------------
`define STATUS_RST 7'h06
`define ATT_LAST_CODE 6'h38
`define BASS_MIN_STEPS 4'h9
`define BASS_MAX_STEPS 4'hC
`define TREBLE_MAX_STEPS 3'h3
`define MUTE_COEFS 6'h20
`define MUTE_HOLD 5'h1F

`endif

// ==== inc/audio_ctrl_pkg.sv ====
// types shared by the serial control decoder
package audio_ctrl_pkg;
	typedef enum logic [1:0] {
		TONE_FLAT = 2'h0,
		TONE_MIN = 2'h1,
		TONE_MAX = 2'h2
	} tone_set_t;

	typedef enum logic [1:0] {
		ROUTE_MUTE = 2'h0,
		ROUTE_RIGHT = 2'h1,
		ROUTE_LEFT = 2'h2,
		ROUTE_MIX = 2'h3
	} route_t;

	typedef enum logic [1:0] {
		GRP_LEVEL = 2'h0,
		GRP_UNUSED1 = 2'h1,
		GRP_STATUS = 2'h2,
		GRP_UNUSED3 = 2'h3
	} group_t;

	typedef struct packed {
		logic [2:0] lnk_s1;
		logic [2:0] lnk_s2;
		logic [1:0] lnk_s3;
		logic src_s1;
		logic src_s2;
		logic [2:0] bit_cnt;
		logic [6:0] shift;
		logic selected;
		logic [1:0] group;
		logic [1:0][5:0] att_code;
		logic [4:0] bass_code;
		logic [4:0] treble_code;
		logic [6:0] status;
		logic [1:0][5:0] att_db;
		logic [1:0] att_mute;
		logic [1:0] tone_set;
		logic [4:0] bass_db;
		logic [4:0] treble_db;
		logic deemph;
		logic [1:0][1:0] src;
		logic [1:0][5:0] mute_lvl;
		logic [1:0][4:0] mute_cnt;
		logic [1:0] clip;
	} ctrl_state_t;
endpackage

// ==== tb/link_master.sv ====
// behavioural model of the controller that writes the serial control link
module link_master (
	input wire logic core_clk,
	output logic data_pin,
	output logic frame_pin,
	output logic clock_pin
);
	timeunit 1ns;
	timeprecision 1ns;

	// clock idles high and stands still between frames
	initial begin
		data_pin = 1'b0;
		frame_pin = 1'b1;
		clock_pin = 1'b1;
	end

	// one byte, msb first, eight clock pulses of 320 ns
	task automatic xfer(input logic mode, input logic [7:0] b);
		@(negedge core_clk);
		frame_pin = mode;
		#160;
		for (int i = 7; i >= 0; i--) begin
			clock_pin = 1'b0;
			data_pin = b[i];
			#160;
			clock_pin = 1'b1;
			#160;
		end
		// released line must not keep showing the last bit
		data_pin = ~data_pin;
	endtask

	// static-pin levels: data is left mute, mode line is right mute
	task automatic set_pins(input logic lmute_pin, input logic rmute_pin);
		@(negedge core_clk);
		data_pin = lmute_pin;
		frame_pin = rmute_pin;
	endtask
endmodule

// ==== tb/tb_audio_dac_serial_control_decoder.sv ====
// self-checking bench for the serial control decoder
module tb_audio_dac_serial_control_decoder import audio_ctrl_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;

	localparam logic [5:0] DEV = 6'h15; // arbitrary value
	localparam logic [5:0] WRONG = 6'h16;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic css = 1'b1;
	logic sample_tick = 1'b0;
	logic d, f, c, link_selected, lmute, rmute, deemph, lhr, rhr;
	logic [5:0] latt, ratt, lml, rml;
	logic [1:0] tone, lsrc, rsrc;
	logic [4:0] bass, treb;
	int miscompares = 0;
	int tests_run = 0;
	logic [5:0] acode [6] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h38, 6'h39};
	logic [7:0] adb [6] = '{8'h00, 8'h00, 8'h01, 8'h02, 8'h37, 8'h00};

	// 25 MHz core clock
	always #20 core_clk = ~core_clk;

	link_master lm (.core_clk(core_clk), .data_pin(d), .frame_pin(f), .clock_pin(c));

	audio_dac_serial_control_decoder #(.DEVICE_ADDR(DEV)) DUT (
		.core_clk(core_clk), .sys_rst(sys_rst), .ctrl_data_line(d), .ctrl_framing_line(f),
		.ctrl_clock_line(c), .control_source_select(css), .sample_tick(sample_tick),
		.link_selected(link_selected), .left_att_db(latt), .right_att_db(ratt),
		.left_att_mute(lmute), .right_att_mute(rmute), .tone_set(tone), .bass_gain_db(bass),
		.treble_gain_db(treb), .deemph_active(deemph), .left_source(lsrc), .right_source(rsrc),
		.left_mute_level(lml), .right_mute_level(rml), .left_headroom_short(lhr),
		.right_headroom_short(rhr)
	);

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic print_verdict();
		$display("comparisons %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %0h seen %0h", what, exp, got);
		end
	endtask

	// byte plus settling time for sync and decode
	task automatic byte_out(input logic mode, input logic [7:0] b);
		lm.xfer(mode, b);
		repeat (10) @(negedge core_clk);
	endtask

	task automatic ticks(input int n);
		repeat (n) begin
			@(negedge core_clk);
			sample_tick = 1'b1;
			@(negedge core_clk);
			sample_tick = 1'b0;
		end
	endtask

	task automatic wait_sel(input logic v);
		int k;
		k = 0;
		while (link_selected !== v && k < 40) begin
			@(negedge core_clk);
			k++;
		end
		if (link_selected !== v) begin
			miscompares++;
			print_verdict();
		end
	endtask

	// hang guard
	initial begin
		repeat (100000) @(posedge core_clk);
		miscompares++;
		print_verdict();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (16) @(negedge core_clk);
		sys_rst = 1'b0;
		repeat (4) @(negedge core_clk);
		chk("sel", 8'h00, 8'(link_selected));
		chk("lsrc", 8'h02, 8'(lsrc));
		chk("rsrc", 8'h01, 8'(rsrc));
		chk("lml", 8'h20, 8'(lml));
		byte_out(1'b0, {DEV, GRP_LEVEL});
		chk("sel", 8'h01, 8'(link_selected));
		// many bytes under one selection, codes at the mute boundary
		foreach (acode[i]) begin
			byte_out(1'b1, {2'h0, acode[i]});
			if (i < 5) chk("ratt", adb[i], 8'(ratt));
			chk("rmute", 8'(i == 5), 8'(rmute));
		end
		byte_out(1'b1, 8'h05);
		byte_out(1'b1, 8'h78);
		chk("ratt", 8'h04, 8'(ratt));
		chk("latt", 8'h37, 8'(latt));
		byte_out(1'b0, {DEV, GRP_STATUS});
		byte_out(1'b1, 8'h6D);
		chk("tone", 8'h02, 8'(tone));
		chk("rsrc", 8'h03, 8'(rsrc));
		chk("lsrc", 8'h01, 8'(lsrc));
		byte_out(1'b1, 8'h80);
		chk("tone", 8'h02, 8'(tone));
		// bit 5 set on the bass byte is don't-care
		byte_out(1'b0, {DEV, GRP_LEVEL});
		byte_out(1'b1, 8'hAC);
		byte_out(1'b1, 8'hC7);
		chk("bass", 8'h18, 8'(bass));
		chk("treb", 8'h06, 8'(treb));
		chk("rhr", 8'h01, 8'(rhr));
		chk("lhr", 8'h00, 8'(lhr));
		byte_out(1'b0, {DEV, GRP_STATUS});
		byte_out(1'b1, 8'h2D);
		chk("bass", 8'h12, 8'(bass));
		byte_out(1'b1, 8'h4D);
		chk("tone", 8'h01, 8'(tone));
		byte_out(1'b1, 8'h1D);
		chk("bass", 8'h00, 8'(bass));
		chk("treb", 8'h00, 8'(treb));
		chk("deemph", 8'h00, 8'(deemph));
		ticks(1);
		chk("deemph", 8'h01, 8'(deemph));
		// left routed to mute ramps down one step after 32 samples
		byte_out(1'b1, 8'h04);
		ticks(48);
		chk("lml", 8'h1F, 8'(lml));
		chk("rml", 8'h20, 8'(rml));
		chk("deemph", 8'h00, 8'(deemph));
		byte_out(1'b0, {WRONG, GRP_LEVEL});
		wait_sel(1'b0);
		byte_out(1'b1, 8'h00);
		chk("ratt", 8'h04, 8'(ratt));
		// static-pin mode: idle link clock reads as de-emphasis on
		// the last byte leaves data high, which pin mode would read as a left mute
		lm.set_pins(1'b0, 1'b0);
		css = 1'b0;
		repeat (4) @(negedge core_clk);
		ticks(2);
		chk("tone", 8'h00, 8'(tone));
		chk("latt", 8'h00, 8'(latt));
		chk("ratt", 8'h00, 8'(ratt));
		chk("lsrc", 8'h02, 8'(lsrc));
		chk("rsrc", 8'h01, 8'(rsrc));
		chk("deemph", 8'h01, 8'(deemph));
		print_verdict();
	end
endmodule
